// ===== vout_regs.svh
`ifndef VOUT_REGS_SVH
`define VOUT_REGS_SVH
// command codes and page values
`define CMD_STORE_USER      8'h15
`define CMD_RESTORE_USER    8'h16
`define CMD_FORMAT          8'h20
`define CMD_TARGET          8'h21
`define CMD_TRIM            8'h22
`define CMD_CAL             8'h23
`define CMD_CEILING         8'h24
`define PAGE_CTL0           8'h00
`define PAGE_CTL1           8'h01
`define PAGE_BOTH           8'hff
// format report fields
`define FORMAT_MODE_LINEAR  3'h0
`define FORMAT_EXPONENT     5'h13
`define FORMAT_VALUE        {`FORMAT_MODE_LINEAR, `FORMAT_EXPONENT}
// scaling and limits, one lsb is 2^-13 volt
`define LSB_PER_VOLT        8192
`define TRIM_RANGE_MV       150
`define TRIM_LIMIT          ((`TRIM_RANGE_MV * `LSB_PER_VOLT) / 1000)
`define CEILING_RANGE_MV    5500
`define CEILING_LIMIT       ((`CEILING_RANGE_MV * `LSB_PER_VOLT) / 1000)
`define STRAP_PCT           115
// reset values
`define TRIM_RESET          16'h0000
`define CAL_RESET           16'h0000
`define SECURITY_RESET      2'h0
`define SECURITY_AFTER_LOAD 2'h1
// store timing
`define CLK_HZ              10000000
`define BUSY_MS             100
`define BUSY_CYCLES         ((`BUSY_MS * `CLK_HZ) / 1000)
`endif

// ===== vout_pkg.sv
package vout_pkg;
    typedef logic [15:0] word_t;
    // word index is page * 4 + target, trim, cal, ceiling
    typedef word_t [7:0] image_t;
    typedef enum logic [1:0] {ST_CAPTURE, ST_LOAD, ST_SAVE, ST_IDLE} ctrl_e;
    typedef enum logic [1:0] {SS_IDLE, SS_SAVE, SS_LOAD} store_e;
endpackage : vout_pkg

// ===== store_if.sv
`timescale 1ns/1ps
`default_nettype none
interface store_if;
    import vout_pkg::*;
    logic   save_req;
    logic   load_req;
    image_t save_image;
    logic   busy;
    logic   done;
    logic   load_valid;
    image_t load_image;
    modport ctrl (output save_req, load_req, save_image,
                  input busy, done, load_valid, load_image);
    modport store (input save_req, load_req, save_image,
                   output busy, done, load_valid, load_image);
endinterface : store_if
`default_nettype wire

// ===== target_calc.sv
`timescale 1ns/1ps
`default_nettype none
module target_calc (
    // operating settings
    input  wire vout_pkg::word_t target,
    input  wire vout_pkg::word_t trim,
    input  wire vout_pkg::word_t cal,
    input  wire vout_pkg::word_t ceiling,
    // result
    output vout_pkg::word_t      effective
);
    import vout_pkg::*;
    logic signed [17:0] sum;

    // 18 bits cannot overflow for three 16-bit terms
    always_comb begin
        sum = $signed({2'h0, target}) + $signed({{2{trim[15]}}, trim})
            + $signed({{2{cal[15]}}, cal});
        if (sum < 18'sh0) begin // [RULE_20]
            effective = 16'h0000;
        end else if (sum > $signed({2'h0, ceiling})) begin
            effective = ceiling; // [RULE_15] [RULE_16]
        end else begin
            effective = sum[15:0];
        end
    end
endmodule : target_calc
`default_nettype wire

// ===== user_store.sv
`timescale 1ns/1ps
`default_nettype none
`include "vout_regs.svh"
module user_store #(
    parameter int unsigned BUSY_CYCLES = `BUSY_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // controller side
    store_if.store    port
);
    import vout_pkg::*;
    store_e      st_q, st_d;
    logic [31:0] cnt_q, cnt_d;
    logic [31:0] run_q, run_d;
    logic        valid_q, valid_d;
    logic        done_q, done_d;
    image_t      mem_q, mem_d;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        valid_d = valid_q;
        done_d = 1'b0;
        mem_d = mem_q;
        run_d = port.busy ? run_q + 32'h1 : 32'h0;
        case (st_q)
            SS_IDLE: begin
                if (port.save_req) begin
                    mem_d = port.save_image;
                    valid_d = 1'b1;
                    cnt_d = BUSY_CYCLES - 32'h1;
                    st_d = SS_SAVE;
                end else if (port.load_req) begin
                    cnt_d = BUSY_CYCLES - 32'h1;
                    st_d = SS_LOAD;
                end
            end
            SS_SAVE, SS_LOAD: begin
                if (cnt_q == 32'h0) begin
                    st_d = SS_IDLE;
                    done_d = 1'b1;
                end else begin
                    cnt_d = cnt_q - 32'h1;
                end
            end
            default: st_d = SS_IDLE;
        endcase
    end

    // contents survive reset; the valid mark, state and counters are cleared
    always_ff @(posedge clk) begin
        mem_q <= mem_d;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= SS_IDLE;
            cnt_q <= 32'h0;
            valid_q <= 1'b0;
            done_q <= 1'b0;
            run_q <= 32'h0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            valid_q <= valid_d;
            done_q <= done_d;
            run_q <= run_d;
        end
    end

    assign port.busy = (st_q != SS_IDLE);
    assign port.done = done_q;
    assign port.load_valid = valid_q;
    assign port.load_image = mem_q;

    sequence op_start;
        st_q == SS_IDLE && (port.save_req || port.load_req);
    endsequence
    a_busy_length: assert property (@(posedge clk) disable iff (reset) // [RULE_02]
        $fell(port.busy) |-> run_q == BUSY_CYCLES && port.done)
        else $error("busy period length wrong");
    a_op_holds: assert property (@(posedge clk) disable iff (reset) // [RULE_08]
        op_start |=> port.busy [*8])
        else $error("store dropped busy early");
endmodule : user_store
`default_nettype wire

// ===== output_voltage_setpoint_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "vout_regs.svh"
// Operation
// [RULE_01] code 15h saves operating settings to store
// [RULE_02] saving keeps device busy for 100 ms
// [RULE_03] host empties store: factory load, then save
// [RULE_04] host adds: restore, write, then save
// [RULE_05] code 16h loads store into operating settings
// [RULE_06] load runs by itself after reset
// [RULE_07] finished load sets security level one
// [RULE_08] loading busy 100 ms, traffic ignored
// [RULE_09] code 20h reads fixed format byte 13h
// [RULE_10] format: mode bits zero, exponent low
// [RULE_11] 21h unsigned setpoint, default from strap
// [RULE_12] setpoint capped at max of 115%, ceiling
// [RULE_13] 22h signed trim, reset zero, 150 mV
// [RULE_14] 23h signed calibration offset, reset zero
// [RULE_15] commanded output never exceeds the ceiling
// [RULE_16] setpoint above ceiling drives the ceiling
// [RULE_17] ceiling never rescaled by setpoint changes
// [RULE_18] ceiling defaults 1.15 strap, capped 5.5V
// [RULE_19] page picks controller 0, 1 or both
// [RULE_20] output is saturated sum clamped to ceiling
// [RULE_21] busy store or load refuses transactions
module output_voltage_setpoint_regs #(
    parameter int unsigned BUSY_CYCLES = `BUSY_CYCLES
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // strap and page select
    input  wire vout_pkg::word_t  voltage_strap_setting,
    input  wire logic [7:0]       page_select,
    // command transaction
    input  wire logic             txn_valid,
    input  wire logic             txn_write,
    input  wire logic [7:0]       txn_code,
    input  wire vout_pkg::word_t  txn_wdata,
    // transaction answer
    output logic                  txn_ack,
    output logic                  txn_nack,
    output vout_pkg::word_t       txn_rdata,
    // regulator side
    output vout_pkg::word_t       effective_target_0,
    output vout_pkg::word_t       effective_target_1,
    output logic [1:0]            security_level,
    output logic                  store_busy
);
    import vout_pkg::*;

    localparam word_t TRIM_LIM = 16'(`TRIM_LIMIT);
    localparam word_t CEIL_LIM = 16'(`CEILING_LIMIT);

    function automatic word_t clamp_unsigned(input word_t v,
                                             input word_t lim);
        return (v > lim) ? lim : v;
    endfunction : clamp_unsigned

    function automatic word_t clamp_signed(input word_t v,
                                           input word_t lim);
        word_t neg;
        neg = 16'(~lim + 16'h1);
        if ($signed(v) > $signed(lim)) begin
            return lim;
        end else if ($signed(v) < $signed(neg)) begin
            return neg;
        end
        return v;
    endfunction : clamp_signed

    function automatic word_t pct115(input word_t v);
        logic [31:0] p;
        p = (32'(v) * 32'(`STRAP_PCT)) / 32'h64;
        return (p > 32'h0000ffff) ? 16'hffff : p[15:0];
    endfunction : pct115

    store_if sif ();

    ctrl_e        st_q, st_d;
    word_t        s115_q, s115_d;
    word_t [1:0]  target_q, target_d;
    word_t [1:0]  trim_q, trim_d;
    word_t [1:0]  cal_q, cal_d;
    word_t [1:0]  ceil_q, ceil_d;
    word_t [1:0]  eff_q, eff_c;
    logic  [1:0]  sec_q, sec_d;
    logic         ack_q, ack_d;
    logic         nack_q, nack_d;
    word_t        rdata_q, rdata_d;
    logic         save_q, save_d;
    logic         load_q, load_d;
    logic         busy_q;
    logic  [1:0]  sel;
    logic         page_ok;
    logic         rp;

    // page decode
    always_comb begin
        sel[0] = (page_select == `PAGE_CTL0) || // [RULE_19]
                 (page_select == `PAGE_BOTH);
        sel[1] = (page_select == `PAGE_CTL1) ||
                 (page_select == `PAGE_BOTH);
        page_ok = |sel;
        rp = (page_select == `PAGE_CTL1);
    end

    for (genvar p = 0; p < 2; p++) begin : g_calc
        target_calc u_calc (
            .target    (target_q[p]),
            .trim      (trim_q[p]),
            .cal       (cal_q[p]),
            .ceiling   (ceil_q[p]),
            .effective (eff_c[p])
        );
    end

    user_store #(
        .BUSY_CYCLES (BUSY_CYCLES)
    ) u_store (
        .clk   (clk),
        .reset (reset),
        .port  (sif)
    );

    // store image follows the live settings, so restore-edit-save works
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            sif.save_image[p*4]   = target_q[p]; // [RULE_04]
            sif.save_image[p*4+1] = trim_q[p];
            sif.save_image[p*4+2] = cal_q[p];
            sif.save_image[p*4+3] = ceil_q[p];
        end
    end
    assign sif.save_req = save_q;
    assign sif.load_req = load_q;

    always_comb begin
        st_d = st_q;
        s115_d = s115_q;
        target_d = target_q;
        trim_d = trim_q;
        cal_d = cal_q;
        ceil_d = ceil_q;
        sec_d = sec_q;
        ack_d = 1'b0;
        nack_d = 1'b0;
        rdata_d = rdata_q;
        save_d = 1'b0;
        load_d = 1'b0;
        case (st_q)
            ST_CAPTURE: begin
                // strap is sampled only after reset has gone
                s115_d = pct115(voltage_strap_setting);
                for (int p = 0; p < 2; p++) begin
                    target_d[p] = voltage_strap_setting; // [RULE_11]
                    trim_d[p] = `TRIM_RESET; // [RULE_13]
                    cal_d[p] = `CAL_RESET; // [RULE_14]
                    ceil_d[p] = clamp_unsigned( // [RULE_18]
                        pct115(voltage_strap_setting), CEIL_LIM);
                end
                load_d = 1'b1; // [RULE_06]
                st_d = ST_LOAD;
                nack_d = txn_valid;
            end
            ST_LOAD, ST_SAVE: begin
                nack_d = txn_valid; // [RULE_08] [RULE_21]
                if (sif.done) begin
                    if (st_q == ST_LOAD) begin
                        if (sif.load_valid) begin
                            for (int p = 0; p < 2; p++) begin
                                target_d[p] = sif.load_image[p*4];
                                trim_d[p] = sif.load_image[p*4+1];
                                cal_d[p] = sif.load_image[p*4+2];
                                ceil_d[p] = sif.load_image[p*4+3];
                            end
                        end
                        sec_d = `SECURITY_AFTER_LOAD; // [RULE_07]
                    end
                    st_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (txn_valid) begin
                    ack_d = 1'b1;
                    case (txn_code)
                        `CMD_STORE_USER: begin
                            if (txn_write) begin
                                save_d = 1'b1; // [RULE_01] [RULE_02]
                                st_d = ST_SAVE;
                            end else begin
                                ack_d = 1'b0;
                            end
                        end
                        `CMD_RESTORE_USER: begin
                            if (txn_write) begin
                                load_d = 1'b1; // [RULE_05]
                                st_d = ST_LOAD;
                            end else begin
                                ack_d = 1'b0;
                            end
                        end
                        `CMD_FORMAT: begin
                            if (txn_write) begin
                                ack_d = 1'b0;
                            end else begin
                                rdata_d = {8'h00, `FORMAT_VALUE}; // [RULE_09] [RULE_10]
                            end
                        end
                        `CMD_TARGET, `CMD_TRIM, `CMD_CAL, `CMD_CEILING: begin
                            if (!page_ok) begin
                                ack_d = 1'b0;
                            end else if (!txn_write) begin
                                case (txn_code)
                                    `CMD_TARGET: rdata_d = target_q[rp];
                                    `CMD_TRIM:   rdata_d = trim_q[rp];
                                    `CMD_CAL:    rdata_d = cal_q[rp];
                                    default:     rdata_d = ceil_q[rp];
                                endcase
                            end else begin
                                for (int p = 0; p < 2; p++) begin
                                    if (sel[p]) begin
                                        case (txn_code)
                                            `CMD_TARGET: target_d[p] =
                                                clamp_unsigned(txn_wdata,
                                                (ceil_q[p] > s115_q) ?
                                                ceil_q[p] : s115_q); // [RULE_12]
                                            `CMD_TRIM: trim_d[p] =
                                                clamp_signed(txn_wdata,
                                                TRIM_LIM); // [RULE_13]
                                            `CMD_CAL: cal_d[p] =
                                                clamp_signed(txn_wdata,
                                                TRIM_LIM); // [RULE_14]
                                            // own value, untouched by setpoint
                                            default: ceil_d[p] =
                                                clamp_unsigned(txn_wdata,
                                                CEIL_LIM); // [RULE_17] [RULE_18]
                                        endcase
                                    end
                                end
                            end
                        end
                        default: ack_d = 1'b0;
                    endcase
                    nack_d = !ack_d;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= ST_CAPTURE;
            s115_q <= 16'h0000;
            target_q <= '0;
            trim_q <= '0;
            cal_q <= '0;
            ceil_q <= '0;
            eff_q <= '0;
            sec_q <= `SECURITY_RESET;
            ack_q <= 1'b0;
            nack_q <= 1'b0;
            rdata_q <= 16'h0000;
            save_q <= 1'b0;
            load_q <= 1'b0;
            busy_q <= 1'b1;
        end else begin
            st_q <= st_d;
            s115_q <= s115_d;
            target_q <= target_d;
            trim_q <= trim_d;
            cal_q <= cal_d;
            ceil_q <= ceil_d;
            eff_q <= eff_c; // [RULE_20]
            sec_q <= sec_d;
            ack_q <= ack_d;
            nack_q <= nack_d;
            rdata_q <= rdata_d;
            save_q <= save_d;
            load_q <= load_d;
            busy_q <= (st_d != ST_IDLE);
        end
    end

    assign txn_ack = ack_q;
    assign txn_nack = nack_q;
    assign txn_rdata = rdata_q;
    assign effective_target_0 = eff_q[0];
    assign effective_target_1 = eff_q[1];
    assign security_level = sec_q;
    assign store_busy = busy_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence idle_cmd(logic [7:0] code, logic wr);
        st_q == ST_IDLE && txn_valid && txn_write == wr && txn_code == code;
    endsequence

    a_busy_refuses: assert property ( // [RULE_21]
        st_q != ST_IDLE && txn_valid |=> txn_nack && !txn_ack)
        else $error("transaction answered while busy");
    a_format_read: assert property ( // [RULE_09]
        idle_cmd(`CMD_FORMAT, 1'b0) |=> txn_ack && txn_rdata == 16'h0013)
        else $error("format report wrong");
    a_save_starts: assert property ( // [RULE_01]
        idle_cmd(`CMD_STORE_USER, 1'b1) |=> store_busy && sif.save_req
        ##1 sif.busy)
        else $error("save did not start");
    a_load_security: assert property ( // [RULE_07]
        st_q == ST_LOAD && sif.done |=> security_level == 2'h1 && !store_busy)
        else $error("security level not set after load");
    a_ceiling_bound: assert property ( // [RULE_15]
        effective_target_0 <= $past(ceil_q[0])
        && effective_target_1 <= $past(ceil_q[1]))
        else $error("output above ceiling");
    a_trim_range: assert property ( // [RULE_13]
        $signed(trim_q[0]) <= $signed(16'h04cc)
        && $signed(trim_q[0]) >= $signed(16'hfb34)
        && $signed(trim_q[1]) <= $signed(16'h04cc)
        && $signed(trim_q[1]) >= $signed(16'hfb34))
        else $error("trim out of range");
    a_target_limit: assert property ( // [RULE_12]
        idle_cmd(`CMD_TARGET, 1'b1) ##0 sel[0] |=> target_q[0] <=
        ((ceil_q[0] > s115_q) ? ceil_q[0] : s115_q))
        else $error("setpoint above its limit");
    a_ceiling_range: assert property ( // [RULE_18]
        ceil_q[0] <= 16'hb000 && ceil_q[1] <= 16'hb000)
        else $error("ceiling above 5.5 V");
    a_cal_range: assert property ( // [RULE_14]
        $signed(cal_q[0]) <= $signed(16'h04cc)
        && $signed(cal_q[0]) >= $signed(16'hfb34)
        && $signed(cal_q[1]) <= $signed(16'h04cc)
        && $signed(cal_q[1]) >= $signed(16'hfb34))
        else $error("calibration offset out of range");
    a_load_starts: assert property ( // [RULE_05]
        idle_cmd(`CMD_RESTORE_USER, 1'b1) |=> store_busy && sif.load_req
        ##1 sif.busy)
        else $error("load did not start");
    a_startup_load: assert property ( // [RULE_06]
        st_q == ST_CAPTURE |=> st_q == ST_LOAD && sif.load_req)
        else $error("no load after reset");
    a_idle_answer: assert property ( // [RULE_21]
        st_q == ST_IDLE && txn_valid |=> txn_ack ^ txn_nack)
        else $error("idle transaction not answered once");
endmodule : output_voltage_setpoint_regs
`default_nettype wire

// ===== bus_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module bus_host_model (
    // clock
    input  wire logic        clk,
    // request
    output logic             txn_valid,
    output logic             txn_write,
    output logic [7:0]       txn_code,
    output logic [15:0]      txn_wdata,
    output logic [7:0]       page_select,
    // answer
    input  wire logic        txn_ack,
    input  wire logic        txn_nack,
    input  wire logic [15:0] txn_rdata
);
    initial begin
        txn_valid = 1'b0;
        txn_write = 1'b0;
        txn_code = 8'h00;
        txn_wdata = 16'h0000;
        page_select = 8'h00;
    end

    // one command; answer taken one edge later, then lines let go
    task automatic xfer(input logic w, input logic [7:0] code,
                        input logic [15:0] wd, input logic [7:0] pg,
                        output logic [1:0] an, output logic [15:0] rd);
        @(posedge clk);
        #1;
        txn_valid = 1'b1;
        txn_write = w;
        txn_code = code;
        txn_wdata = wd;
        page_select = pg;
        @(posedge clk);
        #1;
        an = {txn_ack, txn_nack};
        rd = txn_rdata;
        txn_valid = 1'b0;
        // released lines must not keep looking valid
        txn_write = ~w;
        txn_code = ~code;
        txn_wdata = ~wd;
    endtask : xfer
endmodule : bus_host_model
`default_nettype wire

// ===== output_voltage_setpoint_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module output_voltage_setpoint_regs_tb_top;
    import vout_pkg::*;
    localparam int BUSY = 20;
    localparam int S115 = 9420;
    logic       clk;
    logic       reset;
    word_t      strap;
    logic       txn_valid;
    logic       txn_write;
    logic [7:0] txn_code;
    logic [7:0] page_select;
    word_t      txn_wdata;
    word_t      txn_rdata;
    word_t      eff0;
    word_t      eff1;
    logic       txn_ack;
    logic       txn_nack;
    logic       store_busy;
    logic [1:0] sec;
    logic [1:0] an;
    word_t      rd;
    int         errors;
    int         samples_checked;
    int         seed;
    int         k;
    int         tgt[2];
    int         trm[2];
    int         cal[2];
    int         ceil[2];

    output_voltage_setpoint_regs #(.BUSY_CYCLES(BUSY))
        u_output_voltage_setpoint_regs (
        .clk(clk), .reset(reset), .voltage_strap_setting(strap),
        .page_select(page_select), .txn_valid(txn_valid),
        .txn_write(txn_write), .txn_code(txn_code),
        .txn_wdata(txn_wdata), .txn_ack(txn_ack), .txn_nack(txn_nack),
        .txn_rdata(txn_rdata), .effective_target_0(eff0),
        .effective_target_1(eff1), .security_level(sec),
        .store_busy(store_busy));

    bus_host_model u_bus_host_model (
        .clk(clk), .txn_valid(txn_valid), .txn_write(txn_write),
        .txn_code(txn_code), .txn_wdata(txn_wdata),
        .page_select(page_select), .txn_ack(txn_ack),
        .txn_nack(txn_nack), .txn_rdata(txn_rdata));

    initial clk = 1'b0;
    always #50 clk = ~clk;

    task automatic test_done;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    task automatic chk(input word_t got, input word_t exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic int val(input logic [7:0] code, input int i);
        case (code)
            8'h21: return tgt[i];
            8'h22: return trm[i];
            8'h23: return cal[i];
            default: return ceil[i];
        endcase
    endfunction : val

    function automatic word_t eff_f(input int i);
        int s;
        s = tgt[i] + trm[i] + cal[i];
        if (s < 0) s = 0;
        if (s > ceil[i]) s = ceil[i];
        return word_t'(s);
    endfunction : eff_f

    task automatic mirror_defaults;
        for (int i = 0; i < 2; i++) begin
            tgt[i] = 'h2000;
            trm[i] = 0;
            cal[i] = 0;
            ceil[i] = S115;
        end
    endtask : mirror_defaults

    task automatic xf(input logic w, input logic [7:0] code, input int v,
                      input logic [7:0] pg, input logic [1:0] exp_an);
        u_bus_host_model.xfer(w, code, word_t'(v), pg, an, rd);
        chk({14'h0, an}, {14'h0, exp_an});
    endtask : xf

    task automatic chk_eff;
        @(posedge clk);
        #1;
        chk(eff0, eff_f(0));
        chk(eff1, eff_f(1));
    endtask : chk_eff

    task automatic wait_idle;
        int n;
        n = 0;
        while (store_busy !== 1'b0 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(word_t'(n < 200), 16'h0001);
    endtask : wait_idle

    // write one register, mirror device clamps, read it back
    task automatic put(input logic [7:0] code, input int v,
                       input logic [7:0] pg);
        int i;
        int w;
        int lim;
        w = v & 'hffff;
        xf(1'b1, code, v, pg, 2'b10);
        for (i = 0; i < 2; i++) begin
            if (pg == 8'hff || pg == i[7:0]) begin
                lim = (S115 > ceil[i]) ? S115 : ceil[i];
                case (code)
                    8'h21: tgt[i] = (w > lim) ? lim : w;
                    8'h22: trm[i] = (v > 1228) ? 1228 :
                                    (v < -1228) ? -1228 : v;
                    8'h23: cal[i] = (v > 1228) ? 1228 :
                                    (v < -1228) ? -1228 : v;
                    default: ceil[i] = (w > 'hb000) ? 'hb000 : w;
                endcase
            end
        end
        xf(1'b0, code, 0, pg, 2'b10);
        chk(rd, word_t'(val(code, (pg == 8'h01) ? 1 : 0)));
        chk_eff();
    endtask : put

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        test_done();
    end

    initial begin
        seed = 66;
        errors = 0;
        samples_checked = 0;
        reset = 1'b1;
        strap = 16'h2000;
        repeat (6) @(posedge clk);
        #1;
        chk({14'h0, sec}, 16'h0000);
        reset = 1'b0;
        mirror_defaults();
        xf(1'b0, 8'h20, 0, 8'h00, 2'b01);
        wait_idle();
        chk({14'h0, sec}, 16'h0001);
        chk_eff();
        xf(1'b0, 8'h20, 0, 8'h00, 2'b10);
        chk(rd, 16'h0013);
        xf(1'b1, 8'h20, 'h55, 8'h00, 2'b01);
        xf(1'b0, 8'h15, 0, 8'h00, 2'b01);
        xf(1'b1, 8'h21, 'h10, 8'h02, 2'b01);
        put(8'h24, 'hffff, 8'h00);
        put(8'h21, 'hffff, 8'h00);
        put(8'h24, 'h1000, 8'h00);
        put(8'h22, -2000, 8'hff);
        put(8'h23, 2000, 8'h01);
        put(8'h21, 0, 8'h01);
        for (k = 0; k < 40; k++) begin
            case ($unsigned($random(seed)) % 4)
                0: put(8'h21, $random(seed), 8'h00);
                1: put(8'h22, $random(seed) % 2001, 8'hff);
                2: put(8'h23, $random(seed) % 2001, 8'h01);
                default: put(8'h24, $random(seed), 8'h01);
            endcase
        end
        put(8'h22, 100, 8'hff);
        xf(1'b1, 8'h15, 0, 8'h00, 2'b10);
        chk({15'h0, store_busy}, 16'h0001);
        xf(1'b1, 8'h22, 5, 8'h00, 2'b01);
        wait_idle();
        put(8'h22, 300, 8'hff);
        xf(1'b1, 8'h16, 0, 8'h00, 2'b10);
        xf(1'b0, 8'h22, 0, 8'h00, 2'b01);
        wait_idle();
        trm[0] = 100;
        trm[1] = 100;
        xf(1'b0, 8'h22, 0, 8'h01, 2'b10);
        chk(rd, 16'h0064);
        chk_eff();
        chk({14'h0, sec}, 16'h0001);
        xf(1'b0, 8'h16, 0, 8'h00, 2'b01);
        xf(1'b1, 8'h25, 'hffff, 8'h00, 2'b01);
        chk_eff();
        // second reset: settings fall back to strap defaults
        reset = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk({14'h0, sec}, 16'h0000);
        chk({15'h0, store_busy}, 16'h0001);
        reset = 1'b0;
        mirror_defaults();
        wait_idle();
        chk_eff();
        // factory state then save leaves only defaults in the store
        xf(1'b1, 8'h15, 0, 8'h00, 2'b10);
        wait_idle();
        put(8'h23, 50, 8'hff);
        xf(1'b1, 8'h16, 0, 8'h00, 2'b10);
        wait_idle();
        cal[0] = 0;
        cal[1] = 0;
        xf(1'b0, 8'h23, 0, 8'hff, 2'b10);
        chk(rd, 16'h0000);
        chk_eff();
        chk({14'h0, sec}, 16'h0001);
        test_done();
    end
endmodule : output_voltage_setpoint_regs_tb_top
`default_nettype wire
